// file: dpg_clock_gen.sv
`timescale 1ns/1ps
`default_nettype none
`include "dpg_map.svh"

module dpg_clock_gen
   import dpg_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_resetn,
   input wire logic i_xtal_tick,
   input wire logic i_vco_tick,
   input wire logic i_external_mod_clock_in,
   dpg_tick_if.gen tk
);

   logic [3:0] xdiv_reg;
   logic ext_prev_reg;
   logic [5:0] pre_cnt_reg;
   logic src_tick;
   logic [5:0] pre_limit;

   // ****************************************
   // Source selection
   // ****************************************
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         xdiv_reg <= 4'h0;
      end else if (i_xtal_tick) begin
         xdiv_reg <= (xdiv_reg == `DPG_XTAL_DIV) ? 4'h0 : xdiv_reg + 4'h1;
      end
   end

   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         ext_prev_reg <= 1'b0;
      end else begin
         ext_prev_reg <= i_external_mod_clock_in;
      end
   end

   always_comb begin
      unique case (tk.src_sel)
         DPG_SRC_XTAL15: src_tick = i_xtal_tick && (xdiv_reg == `DPG_XTAL_DIV);
         DPG_SRC_XTAL: src_tick = i_xtal_tick;
         DPG_SRC_EXT: src_tick = i_external_mod_clock_in && !ext_prev_reg;
         DPG_SRC_VCO: src_tick = i_vco_tick;
      endcase
   end

   // ****************************************
   // Prescaler
   // ****************************************
   always_comb begin
      unique case (tk.pre_sel)
         DPG_PRE_1: pre_limit = 6'h00;
         DPG_PRE_4: pre_limit = 6'h03;
         DPG_PRE_16: pre_limit = 6'h0f;
         DPG_PRE_64: pre_limit = 6'h3f;
      endcase
   end

   // A restart clears the prescaler so the first counter step after a control write is a full step, except behind the free-running crystal/15 divider.
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         pre_cnt_reg <= 6'h00;
      end else if (tk.restart) begin
         pre_cnt_reg <= 6'h00;
      end else if (src_tick) begin
         pre_cnt_reg <= (pre_cnt_reg >= pre_limit) ? 6'h00 : pre_cnt_reg + 6'h01;
      end
   end

   assign tk.tick = src_tick && !tk.restart && (pre_cnt_reg >= pre_limit);

   pre_div_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
      tk.tick |-> pre_cnt_reg == pre_limit) else $error("counter step off prescale boundary");

endmodule : dpg_clock_gen

`default_nettype wire

// file: dpg_load_model.sv
`timescale 1ns/1ps
`default_nettype none

module dpg_load_model (
   input wire logic i_out0,
   input wire logic i_out1,
   input wire logic i_drive_en,
   output logic o_port_pin_a,
   output logic o_port_pin_b
);
   // ****************************************
   // Port pins with pull-ups
   // ****************************************
   // A released pin floats up to its pull-up, so the last driven level is never seen.
   assign o_port_pin_a = i_drive_en ? i_out0 : 1'b1;
   assign o_port_pin_b = i_drive_en ? i_out1 : 1'b1;
endmodule : dpg_load_model

`default_nettype wire

// file: dpg_map.svh
`ifndef DPG_MAP_SVH
`define DPG_MAP_SVH

// ****************************************
// Register addresses in the SFR space
// ****************************************
`define DPG_ADDR_CTRL 8'hae
`define DPG_ADDR_CH0_LOW 8'hb1
`define DPG_ADDR_CH0_HIGH 8'hb2
`define DPG_ADDR_CH1_LOW 8'hb3
`define DPG_ADDR_CH1_HIGH 8'hb4

// ****************************************
// Control register fields and reset
// ****************************************
`define DPG_CTRL_RESET 8'h00
`define DPG_MODE_MSB 6
`define DPG_MODE_LSB 4
`define DPG_PRE_MSB 3
`define DPG_PRE_LSB 2
`define DPG_SRC_MSB 1
`define DPG_SRC_LSB 0
`define DPG_CTRL_USED_MASK 8'h7f
`define DPG_DATA_RESET 8'h00

// ****************************************
// Counts
// ****************************************
`define DPG_XTAL_DIV 4'he
`define DPG_CNT_FULL 16'hffff

`endif

// file: dpg_modulator.sv
`timescale 1ns/1ps
`default_nettype none
`include "dpg_map.svh"

// Overview of operation
// - Any control register write clears the counter and restarts the cycle.
// - In 16-bit modes the low byte goes to a hidden holding register first.
// - A high byte write commits both bytes; they govern the next cycle.
// - Control bits 6..4 select mode 0..6; code 7 and bit 7 reserved.
// - Control bits 3..2 divide the counter clock by 1, 4, 16 or 64.
// - Control bits 1..0 select crystal/15, crystal, external pin or VCO clock.
// - Mode zero releases both output pins to their port function.
// - Single mode: channel one's 16-bit value sets the counter period.
// - Single mode: channel zero's 16-bit value sets the duty cycle.
// - Twin 8-bit mode: channel one's low byte sets the common period.
// - Twin 8-bit mode: output zero goes low when counter equals channel zero low.
// - Twin 8-bit: output one rises at channel one high, falls at channel zero high.
// - Twin 16-bit mode: counter runs over the full fixed 16-bit range.
// - Twin 16-bit: output zero high below channel zero value, low until rollover.
// - Twin 16-bit: output one high below channel one value, low until rollover.
// - Twin 16-bit: outputs with a nonzero value go high together when the counter wraps.

module dpg_modulator
   import dpg_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_resetn,
   input wire logic [7:0] i_sfr_addr,
   input wire logic [7:0] i_sfr_wdata,
   input wire logic i_sfr_wr,
   output logic [7:0] o_sfr_rdata,
   input wire logic i_xtal_tick,
   input wire logic i_vco_tick,
   input wire logic i_external_mod_clock_in,
   output logic o_mod_output_zero,
   output logic o_mod_output_one,
   output logic o_mod_drive_en
);

   logic [7:0] ctrl_reg;
   logic [7:0] hold0_reg;
   logic [7:0] hold1_reg;
   logic [15:0] pend0_reg;
   logic [15:0] pend1_reg;
   logic pend_valid_reg;
   logic [15:0] act0_reg;
   logic [15:0] act1_reg;
   logic [15:0] cnt_reg;
   logic out0_reg;
   logic out1_reg;
   logic drive_reg;
   logic out0_next;
   logic out1_next;
   logic ctrl_wr;
   logic wrap;
   logic is_16bit;
   dpg_mode_t mode;

   dpg_tick_if tk ();

   function automatic logic hit(input logic [7:0] addr);
      hit = i_sfr_wr && (i_sfr_addr == addr);
   endfunction : hit

   // ****************************************
   // Control register
   // ****************************************
   assign mode = dpg_mode_t'(ctrl_reg[`DPG_MODE_MSB:`DPG_MODE_LSB]);
   assign ctrl_wr = hit(`DPG_ADDR_CTRL);
   assign is_16bit = (mode == DPG_MD_SINGLE) || (mode == DPG_MD_TWIN16) ||
                     (mode == DPG_MD_NRZ) || (mode == DPG_MD_RZ);

   // Bit 7 is reserved and is never stored, so it reads as zero.
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         ctrl_reg <= `DPG_CTRL_RESET;
      end else if (ctrl_wr) begin
         ctrl_reg <= i_sfr_wdata & `DPG_CTRL_USED_MASK;
      end
   end

   assign tk.src_sel = dpg_src_t'(ctrl_reg[`DPG_SRC_MSB:`DPG_SRC_LSB]);
   assign tk.pre_sel = dpg_pre_t'(ctrl_reg[`DPG_PRE_MSB:`DPG_PRE_LSB]);
   assign tk.restart = ctrl_wr;

   dpg_clock_gen u_clock_gen (
      .i_clk(i_clk),
      .i_resetn(i_resetn),
      .i_xtal_tick(i_xtal_tick),
      .i_vco_tick(i_vco_tick),
      .i_external_mod_clock_in(i_external_mod_clock_in),
      .tk(tk.gen)
   );

   // ****************************************
   // Data registers with double buffering
   // ****************************************
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         hold0_reg <= `DPG_DATA_RESET;
         hold1_reg <= `DPG_DATA_RESET;
      end else begin
         if (hit(`DPG_ADDR_CH0_LOW)) begin
            hold0_reg <= i_sfr_wdata;
         end
         if (hit(`DPG_ADDR_CH1_LOW)) begin
            hold1_reg <= i_sfr_wdata;
         end
      end
   end

   // A new write in the same cycle as the commit wins: it stays pending for the next cycle.
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         pend0_reg <= {`DPG_DATA_RESET, `DPG_DATA_RESET};
         pend1_reg <= {`DPG_DATA_RESET, `DPG_DATA_RESET};
         pend_valid_reg <= 1'b0;
      end else begin
         if (hit(`DPG_ADDR_CH0_HIGH)) begin
            pend0_reg <= {i_sfr_wdata, hold0_reg};
         end else if (hit(`DPG_ADDR_CH0_LOW) && !is_16bit) begin
            pend0_reg <= {pend0_reg[15:8], i_sfr_wdata};
         end
         if (hit(`DPG_ADDR_CH1_HIGH)) begin
            pend1_reg <= {i_sfr_wdata, hold1_reg};
         end else if (hit(`DPG_ADDR_CH1_LOW) && !is_16bit) begin
            pend1_reg <= {pend1_reg[15:8], i_sfr_wdata};
         end
         if (hit(`DPG_ADDR_CH0_HIGH) || hit(`DPG_ADDR_CH1_HIGH) ||
             (!is_16bit && (hit(`DPG_ADDR_CH0_LOW) || hit(`DPG_ADDR_CH1_LOW)))) begin
            pend_valid_reg <= 1'b1;
         end else if (wrap || ctrl_wr) begin
            pend_valid_reg <= 1'b0;
         end
      end
   end

   // Pending values take effect only at a cycle boundary, so a running pulse is never cut short.
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         act0_reg <= {`DPG_DATA_RESET, `DPG_DATA_RESET};
         act1_reg <= {`DPG_DATA_RESET, `DPG_DATA_RESET};
      end else if ((wrap || ctrl_wr) && pend_valid_reg) begin
         act0_reg <= pend0_reg;
         act1_reg <= pend1_reg;
      end
   end

   // Data registers read back the active values, so software sees what the outputs use, not what is pending.
   always_comb begin
      unique case (i_sfr_addr)
         `DPG_ADDR_CTRL: o_sfr_rdata = ctrl_reg;
         `DPG_ADDR_CH0_LOW: o_sfr_rdata = act0_reg[7:0];
         `DPG_ADDR_CH0_HIGH: o_sfr_rdata = act0_reg[15:8];
         `DPG_ADDR_CH1_LOW: o_sfr_rdata = act1_reg[7:0];
         `DPG_ADDR_CH1_HIGH: o_sfr_rdata = act1_reg[15:8];
         default: o_sfr_rdata = 8'h00;
      endcase
   end

   // ****************************************
   // Modulator counter
   // ****************************************
   // A period at or below the current count wraps at the next step, so shortening it never runs the full range.
   always_comb begin
      wrap = 1'b0;
      if (tk.tick) begin
         unique case (mode)
            DPG_MD_SINGLE: wrap = (cnt_reg >= act1_reg);
            DPG_MD_TWIN8: wrap = (cnt_reg[7:0] >= act1_reg[7:0]);
            DPG_MD_TWIN16: wrap = (cnt_reg == `DPG_CNT_FULL);
            default: wrap = 1'b0;
         endcase
      end
   end

   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         cnt_reg <= 16'h0000;
      end else if (ctrl_wr) begin
         cnt_reg <= 16'h0000;
      end else if (wrap) begin
         cnt_reg <= 16'h0000;
      end else if (tk.tick && (mode == DPG_MD_SINGLE || mode == DPG_MD_TWIN8 || mode == DPG_MD_TWIN16)) begin
         cnt_reg <= cnt_reg + 16'h0001;
      end
   end

   // ****************************************
   // Output shaping
   // ****************************************
   always_comb begin
      out0_next = 1'b0;
      out1_next = 1'b0;
      unique case (mode)
         DPG_MD_SINGLE: begin
            out0_next = (cnt_reg < act0_reg);
         end
         DPG_MD_TWIN8: begin
            out0_next = (cnt_reg[7:0] < act0_reg[7:0]);
            if (cnt_reg[7:0] == act1_reg[15:8]) begin
               out1_next = 1'b1;
            end else if (cnt_reg[7:0] == act0_reg[15:8]) begin
               out1_next = 1'b0;
            end else begin
               out1_next = out1_reg;
            end
         end
         DPG_MD_TWIN16: begin
            out0_next = (cnt_reg < act0_reg);
            out1_next = (cnt_reg < act1_reg);
         end
         default: begin
            out0_next = 1'b0;
            out1_next = 1'b0;
         end
      endcase
   end

   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         out0_reg <= 1'b0;
         out1_reg <= 1'b0;
         drive_reg <= 1'b0;
      end else begin
         out0_reg <= out0_next;
         out1_reg <= out1_next;
         // The sigma-delta and dual 8-bit modes are not built here and release the pins too.
         drive_reg <= (mode == DPG_MD_SINGLE) || (mode == DPG_MD_TWIN8) || (mode == DPG_MD_TWIN16);
      end
   end

   assign o_mod_output_zero = out0_reg;
   assign o_mod_output_one = out1_reg;
   assign o_mod_drive_en = drive_reg;

   // ****************************************
   // Checks
   // ****************************************
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_resetn);

   ctrl_restart_a: assert property (ctrl_wr |=> cnt_reg == 16'h0000)
      else $error("control write did not clear the counter");
   low_hidden_a: assert property (hit(`DPG_ADDR_CH0_LOW) && is_16bit && !pend_valid_reg
      |=> $stable(act0_reg))
      else $error("low byte reached the active value on its own");
   commit_defer_a: assert property (hit(`DPG_ADDR_CH0_HIGH) && !wrap && !ctrl_wr
      |=> $stable(act0_reg) ##0 pend_valid_reg)
      else $error("high byte applied before the cycle ended");
   pins_released_a: assert property ((mode == DPG_MD_OFF || mode == DPG_MD_RSVD)
      |=> !o_mod_drive_en)
      else $error("pins driven in a disabled mode");
   single_period_a: assert property (mode == DPG_MD_SINGLE && tk.tick && !ctrl_wr
      && cnt_reg >= act1_reg |=> cnt_reg == 16'h0000)
      else $error("single mode counter missed its period");
   single_duty_a: assert property (mode == DPG_MD_SINGLE && cnt_reg < act0_reg |=> o_mod_output_zero)
      else $error("single mode output low before duty match");
   twin8_fall_a: assert property (mode == DPG_MD_TWIN8 && cnt_reg[7:0] == act0_reg[7:0]
      |=> !o_mod_output_zero)
      else $error("twin 8-bit output zero not low at match");
   twin8_rise_a: assert property (mode == DPG_MD_TWIN8 && cnt_reg[7:0] == act1_reg[15:8]
      |=> o_mod_output_one)
      else $error("twin 8-bit output one did not rise");
   twin16_sync_a: assert property (mode == DPG_MD_TWIN16 && cnt_reg == 16'h0000 &&
      act0_reg != 16'h0000 && act1_reg != 16'h0000 |=> o_mod_output_zero && o_mod_output_one)
      else $error("twin 16-bit outputs not high together at wrap");
   twin16_duty_a: assert property (mode == DPG_MD_TWIN16 && cnt_reg >= act1_reg
      |=> !o_mod_output_one)
      else $error("twin 16-bit output one high past its value");
   twin16_low0_a: assert property (mode == DPG_MD_TWIN16 && cnt_reg >= act0_reg
      |=> !o_mod_output_zero)
      else $error("twin 16-bit output zero high past its value");
   twin16_step_a: assert property (mode == DPG_MD_TWIN16 && tk.tick && !ctrl_wr
      && cnt_reg != `DPG_CNT_FULL |=> cnt_reg == $past(cnt_reg) + 16'h0001)
      else $error("twin 16-bit counter skipped a step");
   twin16_roll_a: assert property (mode == DPG_MD_TWIN16 && tk.tick && !ctrl_wr
      && cnt_reg == `DPG_CNT_FULL |=> cnt_reg == 16'h0000)
      else $error("twin 16-bit counter did not roll over");
   twin8_period_a: assert property (mode == DPG_MD_TWIN8 && tk.tick && !ctrl_wr
      && cnt_reg[7:0] >= act1_reg[7:0] |=> cnt_reg == 16'h0000)
      else $error("twin 8-bit counter missed its period");
   twin8_fall1_a: assert property (mode == DPG_MD_TWIN8 && cnt_reg[7:0] == act0_reg[15:8]
      && cnt_reg[7:0] != act1_reg[15:8] |=> !o_mod_output_one)
      else $error("twin 8-bit output one did not fall");
   single_low_a: assert property (mode == DPG_MD_SINGLE && cnt_reg >= act0_reg
      |=> !o_mod_output_zero)
      else $error("single mode output high past duty match");
   commit_apply_a: assert property ((wrap || ctrl_wr) && pend_valid_reg
      |=> act0_reg == $past(pend0_reg) && act1_reg == $past(pend1_reg))
      else $error("pending values not applied at the cycle boundary");

   // ****************************************
   // Coverage
   // ****************************************
   wrap16_c: cover property (mode == DPG_MD_TWIN16 && wrap);
   commit_c: cover property (pend_valid_reg && wrap);
   twin8_pulse_c: cover property (mode == DPG_MD_TWIN8 && !o_mod_output_one ##1 o_mod_output_one);
   twin8_end_c: cover property (mode == DPG_MD_TWIN8 && o_mod_output_one ##1 !o_mod_output_one);
   single_wrap_c: cover property (mode == DPG_MD_SINGLE && wrap);

endmodule : dpg_modulator

`default_nettype wire

// file: dpg_pkg.sv
package dpg_pkg;

   typedef enum logic [2:0] {
      DPG_MD_OFF,
      DPG_MD_SINGLE,
      DPG_MD_TWIN8,
      DPG_MD_TWIN16,
      DPG_MD_NRZ,
      DPG_MD_DUAL8,
      DPG_MD_RZ,
      DPG_MD_RSVD
   } dpg_mode_t;

   typedef enum logic [1:0] {
      DPG_PRE_1,
      DPG_PRE_4,
      DPG_PRE_16,
      DPG_PRE_64
   } dpg_pre_t;

   typedef enum logic [1:0] {
      DPG_SRC_XTAL15,
      DPG_SRC_XTAL,
      DPG_SRC_EXT,
      DPG_SRC_VCO
   } dpg_src_t;

endpackage : dpg_pkg

// file: dpg_tick_if.sv
`timescale 1ns/1ps
`default_nettype none

interface dpg_tick_if;
   import dpg_pkg::*;
   dpg_src_t src_sel;
   dpg_pre_t pre_sel;
   logic restart;
   logic tick;
   modport gen (input src_sel, input pre_sel, input restart, output tick);
   modport use_side (output src_sel, output pre_sel, output restart, input tick);
endinterface : dpg_tick_if

`default_nettype wire

// file: test_dpg_modulator.sv
`timescale 1ns/1ps
`default_nettype none
`include "dpg_map.svh"

module test_dpg_modulator
   import dpg_pkg::*;
;
   logic clk, resetn, wr, xt, vco, ext, ext_run, out0, out1, den, pin_a, pin_b;
   logic [7:0] addr, wdata, rdata;
   int miscompares = 0;
   int check_count = 0;
   int cyc = 0;
   int hi_a, hi_b, t0, k;

   dpg_modulator i_dut (.i_clk(clk), .i_resetn(resetn), .i_sfr_addr(addr), .i_sfr_wdata(wdata),
      .i_sfr_wr(wr), .o_sfr_rdata(rdata), .i_xtal_tick(xt), .i_vco_tick(vco),
      .i_external_mod_clock_in(ext), .o_mod_output_zero(out0), .o_mod_output_one(out1),
      .o_mod_drive_en(den));
   dpg_load_model i_load (.i_out0(out0), .i_out1(out1), .i_drive_en(den),
      .o_port_pin_a(pin_a), .o_port_pin_b(pin_b));

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   always @(posedge clk) cyc <= cyc + 1;
   always @(posedge clk) ext <= ext_run ? ~ext : 1'b0;

   // ****************************************
   // Shared tasks
   // ****************************************
   task automatic check(input logic [31:0] got, input logic [31:0] exp, input int tol);
      check_count++;
      if ($isunknown(got) || (tol == 0 ? got !== exp : (got > exp + tol || got + tol < exp))) begin
         miscompares++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check

   function automatic logic [7:0] mk_ctrl(input dpg_mode_t m, input dpg_pre_t p, input dpg_src_t s);
      return {1'b0, m, p, s};
   endfunction : mk_ctrl

   task automatic sfr_write(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask : sfr_write

   task automatic read_check(input logic [7:0] a, input logic [7:0] exp);
      @(posedge clk);
      addr <= a;
      @(negedge clk);
      check({24'h0, rdata}, {24'h0, exp}, 0);
   endtask : read_check

   task automatic setup(input logic [7:0] c, input logic [15:0] v0, input logic [15:0] v1);
      sfr_write(`DPG_ADDR_CTRL, c);
      sfr_write(`DPG_ADDR_CH0_LOW, v0[7:0]);
      sfr_write(`DPG_ADDR_CH0_HIGH, v0[15:8]);
      sfr_write(`DPG_ADDR_CH1_LOW, v1[7:0]);
      sfr_write(`DPG_ADDR_CH1_HIGH, v1[15:8]);
      repeat (20) @(posedge clk);
      sfr_write(`DPG_ADDR_CTRL, c);
   endtask : setup

   // Counts high pin cycles; the first sample is taken where the new counter value shows.
   task automatic sample(input int n);
      hi_a = 0;
      hi_b = 0;
      for (int i = 0; i < n; i++) begin
         @(negedge clk);
         if (i == 0) t0 = cyc;
         if (pin_a === 1'b1) hi_a++;
         if (pin_b === 1'b1) hi_b++;
      end
   endtask : sample

   task automatic measure(input int skip, input int n);
      repeat (1 + skip) @(posedge clk);
      sample(n);
   endtask : measure

   // ****************************************
   // Scenarios
   // ****************************************
   task automatic t_reset();
      logic [7:0] regs[5] = '{`DPG_ADDR_CTRL, `DPG_ADDR_CH0_LOW, `DPG_ADDR_CH0_HIGH,
         `DPG_ADDR_CH1_LOW, `DPG_ADDR_CH1_HIGH};
      foreach (regs[i]) read_check(regs[i], 8'h00);
      check({31'h0, den}, 32'h0, 0);
      check({31'h0, pin_a}, 32'h1, 0);
      sfr_write(8'hb0, 8'h5a);
      read_check(8'hb0, 8'h00);
      read_check(`DPG_ADDR_CTRL, 8'h00);
   endtask : t_reset

   task automatic t_twin16();
      setup(mk_ctrl(DPG_MD_TWIN16, DPG_PRE_1, DPG_SRC_VCO), 16'h0005, 16'h0003);
      measure(0, 16);
      check(hi_a, 5, 0);
      check(hi_b, 3, 0);
      check({31'h0, den}, 32'h1, 0);
   endtask : t_twin16

   task automatic t_prescale();
      for (int p = 0; p < 4; p++) begin
         sfr_write(`DPG_ADDR_CTRL, mk_ctrl(DPG_MD_TWIN16, dpg_pre_t'(p), DPG_SRC_VCO));
         measure(0, (5 << (2 * p)) + 4);
         check(hi_a, 5 << (2 * p), 0);
      end
   endtask : t_prescale

   task automatic t_source();
      @(posedge clk);
      vco <= 1'b0;
      xt <= 1'b1;
      sfr_write(`DPG_ADDR_CTRL, mk_ctrl(DPG_MD_TWIN16, DPG_PRE_1, DPG_SRC_XTAL));
      measure(0, 12);
      check(hi_a, 5, 0);
      // The divide-by-15 phase is free running, so one divided step (15 crystal ticks) of slack is allowed.
      sfr_write(`DPG_ADDR_CTRL, mk_ctrl(DPG_MD_TWIN16, DPG_PRE_1, DPG_SRC_XTAL15));
      measure(0, 95);
      check(hi_a, 75, 15);
      @(posedge clk);
      xt <= 1'b0;
      ext_run <= 1'b1;
      sfr_write(`DPG_ADDR_CTRL, mk_ctrl(DPG_MD_TWIN16, DPG_PRE_1, DPG_SRC_EXT));
      measure(0, 16);
      check(hi_a, 10, 1);
      @(posedge clk);
      ext_run <= 1'b0;
      vco <= 1'b1;
   endtask : t_source

   task automatic t_twin8();
      setup(mk_ctrl(DPG_MD_TWIN8, DPG_PRE_1, DPG_SRC_VCO), 16'h0604, 16'h0209);
      measure(10, 20);
      check(hi_a, 8, 0);
      check(hi_b, 8, 0);
   endtask : t_twin8

   task automatic t_single();
      setup(mk_ctrl(DPG_MD_SINGLE, DPG_PRE_1, DPG_SRC_VCO), 16'h0003, 16'h0007);
      measure(8, 16);
      check(hi_a, 6, 0);
      sfr_write(`DPG_ADDR_CH0_LOW, 8'h05);
      read_check(`DPG_ADDR_CH0_LOW, 8'h03);
      sfr_write(`DPG_ADDR_CH0_HIGH, 8'h00);
      measure(8, 16);
      check(hi_a, 10, 0);
      read_check(`DPG_ADDR_CH0_LOW, 8'h05);
   endtask : t_single

   task automatic t_commit();
      setup(mk_ctrl(DPG_MD_TWIN16, DPG_PRE_1, DPG_SRC_VCO), 16'h0100, 16'h0003);
      measure(0, 16);
      check(hi_a, 16, 0);
      sfr_write(`DPG_ADDR_CH0_LOW, 8'h08);
      sfr_write(`DPG_ADDR_CH0_HIGH, 8'h00);
      repeat (2) @(negedge clk);
      check({31'h0, pin_a}, 32'h1, 0);
      read_check(`DPG_ADDR_CH0_HIGH, 8'h01);
      k = 0;
      while (pin_a !== 1'b0 && k < 400) begin
         @(negedge clk);
         k++;
      end
      k = 0;
      while (pin_a !== 1'b1 && k < 70000) begin
         @(negedge clk);
         k++;
      end
      check(cyc - t0, 65536, 0);
      check({31'h0, pin_b}, 32'h1, 0);
      sample(15);
      check(hi_a, 7, 0);
      check(hi_b, 2, 0);
   endtask : t_commit

   task automatic t_disable();
      sfr_write(`DPG_ADDR_CTRL, 8'h06);
      read_check(`DPG_ADDR_CTRL, 8'h06);
      repeat (3) @(negedge clk);
      check({31'h0, den}, 32'h0, 0);
      check({31'h0, pin_a}, 32'h1, 0);
      sfr_write(`DPG_ADDR_CTRL, 8'h33);
      sfr_write(`DPG_ADDR_CTRL, 8'hf3);
      read_check(`DPG_ADDR_CTRL, 8'h73);
      repeat (3) @(negedge clk);
      check({31'h0, den}, 32'h0, 0);
      check({31'h0, pin_b}, 32'h1, 0);
      for (int m = 4; m < 7; m++) begin
         sfr_write(`DPG_ADDR_CTRL, mk_ctrl(DPG_MD_TWIN16, DPG_PRE_1, DPG_SRC_VCO));
         sfr_write(`DPG_ADDR_CTRL, mk_ctrl(dpg_mode_t'(m), DPG_PRE_1, DPG_SRC_VCO));
         repeat (3) @(negedge clk);
         check({31'h0, den}, 32'h0, 0);
         check({31'h0, pin_a}, 32'h1, 0);
      end
   endtask : t_disable

   // ****************************************
   // Run control
   // ****************************************
   task automatic end_of_test();
      $display("Comparisons: %0d, mismatches: %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : end_of_test

   initial begin
      #900000;
      miscompares++;
      end_of_test();
   end

   initial begin
      resetn = 1'b0;
      addr = 8'h00;
      wdata = 8'h00;
      wr = 1'b0;
      xt = 1'b0;
      vco = 1'b1;
      ext_run = 1'b0;
      repeat (8) @(posedge clk);
      resetn <= 1'b1;
      t_reset();
      t_twin16();
      t_prescale();
      t_source();
      t_twin8();
      t_single();
      t_commit();
      t_disable();
      end_of_test();
   end
endmodule : test_dpg_modulator

`default_nettype wire
